// *** core/dsivp_regs.vh ***
/*
 * constants of the interrupt vector and priority block: trap numbers of the
 * fixed sources, vector offset arithmetic, base pointer split, source masks.
 * assumes it is included by bare name from the core files only.
 */
`ifndef DSIVP_REGS_VH
`define DSIVP_REGS_VH

// ****************************************************************
// trap numbers of the fixed and shared sources
// ****************************************************************
`define DSIVP_TRAP_RESET     5'h00
`define DSIVP_TRAP_NONMASK   5'h01
`define DSIVP_TRAP_EXT0      5'h02
`define DSIVP_TRAP_EXT2      5'h03
`define DSIVP_TRAP_SER1_CARD 5'h07
`define DSIVP_TRAP_EXT3_WDOG 5'h0B
`define DSIVP_TRAP_SER2_CARD 5'h0D
`define DSIVP_TRAP_EXT1      5'h10
`define DSIVP_TRAP_EXT4_RTC  5'h13
`define DSIVP_TRAP_BUS_FAULT 5'h18
`define DSIVP_TRAP_OS_KERNEL 5'h1A

// ****************************************************************
// vector offset and base arithmetic
// ****************************************************************
`define DSIVP_OFFSET_SHIFT   3
`define DSIVP_BASE_SHIFT     8
`define DSIVP_HOST_TRAP_LO   5'h10
`define DSIVP_HOST_TRAP_HI   5'h17

// ****************************************************************
// source masks and reset values
// ****************************************************************
`define DSIVP_NONMASK_SET    32'h0000_0003
`define DSIVP_PERIPH_SLOTS   32'h07F6_D770
`define DSIVP_PEND_RESET     32'h0000_0001
`define DSIVP_PIN_IDLE       5'h1F

`endif

// *** core/dsivp_sync.v ***
/*
 * two flop synchroniser for a group of asynchronous pin levels.
 * assumes the pins are slow levels; the first stage is read only by the
 * second, so nothing downstream sees a metastable value.
 */
`timescale 1ns/1ps
`default_nettype none

module dsivp_sync #(
  parameter W      = 5,
  parameter [W-1:0] IDLE = {W{1'b1}}
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] pin_async,
  output wire [W-1:0] pin_sync
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // ****************************************************************
  // two stage capture
  // ****************************************************************
  // idle level at reset so no false edge appears on release
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;

endmodule

`default_nettype wire

// *** core/dsivp_pick.v ***
/*
 * fixed priority picker: finds the eligible trap with the lowest priority
 * number. assumes eligible is indexed by trap number and is a clean level
 * from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsivp_regs.vh"

module dsivp_pick (
  input  wire [31:0] eligible,
  output reg         found,
  output reg  [4:0]  trap,
  output reg  [4:0]  prio
);

  // ****************************************************************
  // priority to trap table
  // ****************************************************************
  // the fixed ranking; priorities 25 and up equal their trap number
  function [4:0] dsivp_trap_of_prio;
    input [4:0] p;
    begin
      case (p)
        5'd0:    dsivp_trap_of_prio = `DSIVP_TRAP_RESET;
        5'd1:    dsivp_trap_of_prio = `DSIVP_TRAP_NONMASK;
        5'd2:    dsivp_trap_of_prio = `DSIVP_TRAP_BUS_FAULT;
        5'd3:    dsivp_trap_of_prio = `DSIVP_TRAP_EXT0;
        5'd4:    dsivp_trap_of_prio = `DSIVP_TRAP_EXT1;
        5'd5:    dsivp_trap_of_prio = `DSIVP_TRAP_EXT2;
        5'd6:    dsivp_trap_of_prio = 5'd4;
        5'd7:    dsivp_trap_of_prio = 5'd5;
        5'd8:    dsivp_trap_of_prio = 5'd17;
        5'd9:    dsivp_trap_of_prio = 5'd6;
        5'd10:   dsivp_trap_of_prio = `DSIVP_TRAP_SER1_CARD;
        5'd11:   dsivp_trap_of_prio = 5'd8;
        5'd12:   dsivp_trap_of_prio = 5'd18;
        5'd13:   dsivp_trap_of_prio = 5'd9;
        5'd14:   dsivp_trap_of_prio = 5'd10;
        5'd15:   dsivp_trap_of_prio = `DSIVP_TRAP_EXT3_WDOG;
        5'd16:   dsivp_trap_of_prio = `DSIVP_TRAP_EXT4_RTC;
        5'd17:   dsivp_trap_of_prio = 5'd12;
        5'd18:   dsivp_trap_of_prio = `DSIVP_TRAP_SER2_CARD;
        5'd19:   dsivp_trap_of_prio = 5'd20;
        5'd20:   dsivp_trap_of_prio = 5'd21;
        5'd21:   dsivp_trap_of_prio = 5'd14;
        5'd22:   dsivp_trap_of_prio = 5'd15;
        5'd23:   dsivp_trap_of_prio = 5'd22;
        5'd24:   dsivp_trap_of_prio = 5'd23;
        default: dsivp_trap_of_prio = p;
      endcase
    end
  endfunction

  integer i;
  reg [4:0] t;

  // ****************************************************************
  // scan from weakest to strongest so the lowest number wins
  // ****************************************************************
  always @* begin
    found = 1'b0;
    trap  = 5'd0;
    prio  = 5'd0;
    t     = 5'd0;
    for (i = 31; i >= 0; i = i - 1) begin
      t = dsivp_trap_of_prio(i[4:0]);
      if (eligible[t]) begin
        found = 1'b1;
        trap  = t;
        prio  = i[4:0];
      end
    end
  end

endmodule

`default_nettype wire

// *** core/dsivp_ctrl.v ***
/*
 * interrupt vector and priority core: collects pin, peripheral and software
 * requests into pending flags, picks the strongest one and presents its trap,
 * vector offset, priority and absolute vector address to the processor core.
 * assumes peripherals and the core run on clk; external pins are asynchronous
 * and active low; the two base pointers are held stable by the core.
 */
// Notes on behaviour
// - vector byte offset is eight times trap number, 0 up to F8.
// - fixed priorities 0 to 31, lowest number wins; reset, nonmaskable, bus fault first.
// - hardware and software reset both use trap 0, offset 0, priority 0.
// - serial 1 transmit or card 1 request is trap 7, offset 38, priority 10.
// - serial 2 transmit or card 2 request is trap 13, offset 68, priority 18.
// - external 3 or watchdog line is trap 11, offset 58, priority 15.
// - external 4 or clock calendar line is trap 19, offset 98, priority 16.
// - os kernel request is trap 26 at D0; traps 27 to 31 software only.
// - absolute vector address is the selected base plus the vector offset.
// - traps 0 to 15 and 24 to 31 use the data side base.
// - traps 16 to 23 use the host side base.
// - nonmaskable pin is tied inactive high inside; it never raises a request.
// - nonmaskable slot is reachable by software trap 1 and by the watchdog.
// - clock calendar requests are held off while external 4 pin is low.
// - sources sharing one flag are combined with a logical or.
`timescale 1ns/1ps
`default_nettype none
`include "dsivp_regs.vh"

module dsivp_ctrl (
  input  wire        clk,
  input  wire        resetn,
  // asynchronous active low pins
  input  wire        ext_request_0_n,
  input  wire        ext_request_1_n,
  input  wire        ext_request_2_n,
  input  wire        ext_request_3_n,
  input  wire        ext_request_4_n,
  // on-chip one cycle pulses, indexed by trap number
  input  wire [31:0] onchip_request,
  input  wire        serial1_tx_request,
  input  wire        card1_request,
  input  wire        serial2_tx_request,
  input  wire        card2_request,
  input  wire        watchdog_request,
  input  wire        watchdog_to_nonmask,
  input  wire        clock_calendar_request,
  // core side
  input  wire        soft_reset_request,
  input  wire        sw_trap_valid,
  input  wire [4:0]  sw_trap_num,
  input  wire [31:0] irq_enable,
  input  wire        core_ready,
  input  wire [15:0] data_vector_base_pointer,
  input  wire [15:0] host_vector_base_pointer,
  output reg         vec_valid_r,
  output reg  [4:0]  vec_trap_r,
  output reg  [4:0]  vec_prio_r,
  output reg  [7:0]  vec_offset_r,
  output reg         vec_host_base_r,
  output reg  [23:0] vec_addr_r,
  output reg  [31:0] pending_r,
  output reg         clock_calendar_held_r
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // offset of a trap, used by the dispatch path and by address forming
  function [7:0] dsivp_offset;
    input [4:0] trap;
    begin
      dsivp_offset = {3'b000, trap} << `DSIVP_OFFSET_SHIFT;
    end
  endfunction

  // true when a trap vectors relative to the host side base
  function dsivp_is_host;
    input [4:0] trap;
    begin
      dsivp_is_host = (trap >= `DSIVP_HOST_TRAP_LO) &&
                      (trap <= `DSIVP_HOST_TRAP_HI);
    end
  endfunction

  // ****************************************************************
  // pin synchronisation and edge detection
  // ****************************************************************
  wire [4:0] pin_sync;
  reg  [4:0] pin_prev_r;
  wire [4:0] pin_fall;
  // the nonmaskable pin is not brought in at all: it reads as high forever
  wire       nonmask_pin_n = 1'b1;

  dsivp_sync #(
    .W    (5),
    .IDLE (`DSIVP_PIN_IDLE)
  ) u_sync (
    .clk       (clk),
    .resetn    (resetn),
    .pin_async ({ext_request_4_n, ext_request_3_n, ext_request_2_n,
                 ext_request_1_n, ext_request_0_n}),
    .pin_sync  (pin_sync)
  );

  // previous level taken from the second stage only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_r <= `DSIVP_PIN_IDLE;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end

  assign pin_fall = pin_prev_r & ~pin_sync;

  // ****************************************************************
  // clock calendar hold-off behind external 4
  // ****************************************************************
  // a calendar event during a low pin waits here; it is released on the
  // first cycle the pin reads high again, so the event is late, not lost
  wire ext4_low     = ~pin_sync[4];
  wire cal_event    = clock_calendar_request | clock_calendar_held_r;
  wire cal_accept   = cal_event & ~ext4_low;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_calendar_held_r <= 1'b0;
    end else begin
      clock_calendar_held_r <= cal_event & ext4_low;
    end
  end

  // ****************************************************************
  // request collection
  // ****************************************************************
  reg [31:0] set_vec;
  always @* begin
    set_vec = onchip_request & `DSIVP_PERIPH_SLOTS;
    set_vec[`DSIVP_TRAP_EXT0] = pin_fall[0];
    set_vec[`DSIVP_TRAP_EXT1] = pin_fall[1];
    set_vec[`DSIVP_TRAP_EXT2] = pin_fall[2];
    // shared lines merge with a plain or, no selection needed
    set_vec[`DSIVP_TRAP_SER1_CARD] = serial1_tx_request | card1_request;
    set_vec[`DSIVP_TRAP_SER2_CARD] = serial2_tx_request | card2_request;
    set_vec[`DSIVP_TRAP_EXT3_WDOG] = pin_fall[3] |
                                     (watchdog_request & ~watchdog_to_nonmask);
    set_vec[`DSIVP_TRAP_EXT4_RTC]  = pin_fall[4] | cal_accept;
    // nonmaskable slot: software trap 1 or a watchdog routed there
    set_vec[`DSIVP_TRAP_NONMASK] = ~nonmask_pin_n |
                                   (watchdog_request & watchdog_to_nonmask);
    set_vec[`DSIVP_TRAP_RESET] = soft_reset_request;
  end

  // software traps bypass the enable mask, including 27 to 31 which have
  // no hardware source at all
  reg [31:0] sw_set;
  always @* begin
    sw_set = 32'h0000_0000;
    if (sw_trap_valid) begin
      sw_set[sw_trap_num] = 1'b1;
    end
  end

  // ****************************************************************
  // arbitration
  // ****************************************************************
  reg  [31:0] sw_pend_r;
  wire [31:0] eligible = (pending_r & (irq_enable | `DSIVP_NONMASK_SET)) | sw_pend_r;
  wire        win_found;
  wire [4:0]  win_trap;
  wire [4:0]  win_prio;

  dsivp_pick u_pick (
    .eligible (eligible),
    .found    (win_found),
    .trap     (win_trap),
    .prio     (win_prio)
  );

  wire        take = win_found & core_ready;
  wire [31:0] clr  = take ? (32'h0000_0001 << win_trap) : 32'h0000_0000;

  // ****************************************************************
  // pending flags
  // ****************************************************************
  // a new event in the cycle its flag is taken survives: set wins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_r <= `DSIVP_PEND_RESET;
      sw_pend_r <= 32'h0000_0000;
    end else begin
      pending_r <= (pending_r & ~clr) | set_vec;
      sw_pend_r <= (sw_pend_r & ~clr) | sw_set;
    end
  end

  // ****************************************************************
  // vector output
  // ****************************************************************
  wire        host_sel  = dsivp_is_host(win_trap);
  wire [7:0]  win_off   = dsivp_offset(win_trap);
  wire [15:0] base_ptr  = host_sel ? host_vector_base_pointer
                                   : data_vector_base_pointer;
  wire [23:0] base_byte = {base_ptr, 8'h00};
  wire [23:0] win_addr  = base_byte + {16'h0000, win_off};

  // valid pulses one cycle per dispatch; the rest hold until the next one
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vec_valid_r     <= 1'b0;
      vec_trap_r      <= 5'd0;
      vec_prio_r      <= 5'd0;
      vec_offset_r    <= 8'h00;
      vec_host_base_r <= 1'b0;
      vec_addr_r      <= 24'h00_0000;
    end else begin
      vec_valid_r <= take;
      if (take) begin
        vec_trap_r      <= win_trap;
        vec_prio_r      <= win_prio;
        vec_offset_r    <= win_off;
        vec_host_base_r <= host_sel;
        vec_addr_r      <= win_addr;
      end
    end
  end

endmodule

`default_nettype wire

// *** test/dsivp_tb_prio.svh ***
/* fixed priority of every trap, shared by the bench and the checker.
   assumes it is included inside a module body; it has no guard because
   each including module needs its own copy of the function. */
// rank by trap number; the lowest rank wins
function automatic logic [4:0] dsivp_prio(input logic [4:0] t);
  logic [4:0] tab [32];
  tab = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0E,
          5'h0F, 5'h11, 5'h12, 5'h15, 5'h16, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h13, 5'h14,
          5'h17, 5'h18, 5'h02, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  return tab[t];
endfunction

// *** test/dsivp_checker.sv ***
/* concurrent checks on the vector outputs of the interrupt core.
   assumes one clock and the two base pointers held steady. */
`timescale 1ns/1ps
`default_nettype none
module dsivp_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ext_request_4_n,
  input wire logic [31:0] irq_enable,
  input wire logic        core_ready,
  input wire logic [15:0] data_vector_base_pointer,
  input wire logic [15:0] host_vector_base_pointer,
  input wire logic        vec_valid_r,
  input wire logic [4:0]  vec_trap_r,
  input wire logic [4:0]  vec_prio_r,
  input wire logic [7:0]  vec_offset_r,
  input wire logic        vec_host_base_r,
  input wire logic [23:0] vec_addr_r,
  input wire logic [31:0] pending_r,
  input wire logic        clock_calendar_held_r
);
`include "dsivp_tb_prio.svh"
  // smallest rank among a set of traps; 0x20 when the set is empty
  function automatic logic [5:0] min_prio(input logic [31:0] m);
    min_prio = 6'h20;
    for (int i = 0; i < 32; i++)
      if (m[i] && dsivp_prio(i[4:0]) < min_prio) min_prio = {1'b0, dsivp_prio(i[4:0])};
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_offset_eight: assert property (vec_valid_r |-> vec_offset_r == {vec_trap_r, 3'b000})
    else $error("vector offset is not eight times the trap");
  a_prio_table: assert property (vec_valid_r |-> vec_prio_r == dsivp_prio(vec_trap_r))
    else $error("priority does not match trap");
  a_base_split: assert property (vec_valid_r |-> vec_host_base_r == (vec_trap_r[4:3] == 2'b10))
    else $error("wrong base pointer chosen");
  a_abs_address: assert property (vec_valid_r |-> vec_addr_r == {vec_host_base_r ?
      $past(host_vector_base_pointer) : $past(data_vector_base_pointer), 8'h00} + vec_offset_r)
    else $error("absolute vector address wrong");
  a_reset_slot: assert property (vec_valid_r && vec_trap_r == 5'h00 |-> vec_prio_r == 5'h00
      && vec_offset_r == 8'h00 && !vec_host_base_r)
    else $error("reset slot not at offset zero rank zero");
  a_ready_gate: assert property (vec_valid_r |-> $past(core_ready))
    else $error("dispatch without core ready");
  a_lowest_wins: assert property (vec_valid_r |->
      vec_prio_r <= min_prio($past(pending_r) & ($past(irq_enable) | 32'h0000_0003)))
    else $error("a stronger eligible trap was passed over");
  a_cal_hold: assert property (clock_calendar_held_r && !ext_request_4_n
      && !$past(ext_request_4_n) && !$past(ext_request_4_n, 2) |=> clock_calendar_held_r)
    else $error("calendar request let through while pin low");
endmodule
bind dsivp_ctrl dsivp_checker u_chk (.clk(clk), .resetn(resetn),
  .ext_request_4_n(ext_request_4_n), .irq_enable(irq_enable), .core_ready(core_ready),
  .data_vector_base_pointer(data_vector_base_pointer),
  .host_vector_base_pointer(host_vector_base_pointer), .vec_valid_r(vec_valid_r),
  .vec_trap_r(vec_trap_r), .vec_prio_r(vec_prio_r), .vec_offset_r(vec_offset_r),
  .vec_host_base_r(vec_host_base_r), .vec_addr_r(vec_addr_r), .pending_r(pending_r),
  .clock_calendar_held_r(clock_calendar_held_r));
`default_nettype wire

// *** test/dsivp_peer.sv ***
/* far side model: board pins with pull-ups and a core that accepts at once or slowly.
   assumes the bench asks for pin levels and pace after the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module dsivp_peer (
  input  wire logic       clk,
  input  wire logic [4:0] pin_low,
  input  wire logic       slow,
  output wire logic [4:0] pin_n,
  output wire logic       ready
);
  logic [1:0] beat_r = 2'h0;
  // pins idle high through pull-ups; ext4 stays high unless pulled on purpose
  assign pin_n = ~pin_low;
  // slow core is ready one cycle in four, so requests pile up behind it
  always @(posedge clk) beat_r <= beat_r + 2'h1;
  assign ready = !slow || (beat_r == 2'h3);
endmodule
`default_nettype wire

// *** test/dsivp_ctrl_bench.sv ***
/* self-checking bench of the interrupt vector and priority core.
   assumes the peer model drives pins and core pace; pointers are fixed. */
`timescale 1ns/1ps
`default_nettype none
module dsivp_ctrl_bench;
`include "dsivp_tb_prio.svh"
  localparam logic [15:0] DATA_PTR = 16'h12A4;
  localparam logic [15:0] HOST_PTR = 16'h7E30;
  logic clk, resetn, slow, wd_nm, sw_v, ready, valid, hostb, held;
  logic [4:0] pin_low, pin_n, sw_n, trap, prio;
  logic [6:0] side;
  logic [7:0] offs;
  logic [23:0] addr;
  logic [31:0] onchip, enable, pend;
  int err_count, checks, cyc;
  dsivp_peer peer (.clk(clk), .pin_low(pin_low), .slow(slow), .pin_n(pin_n), .ready(ready));
  dsivp_ctrl dut (.clk(clk), .resetn(resetn), .ext_request_0_n(pin_n[0]),
    .ext_request_1_n(pin_n[1]), .ext_request_2_n(pin_n[2]), .ext_request_3_n(pin_n[3]),
    .ext_request_4_n(pin_n[4]), .onchip_request(onchip), .soft_reset_request(side[0]),
    .serial1_tx_request(side[1]), .card1_request(side[2]), .serial2_tx_request(side[3]),
    .card2_request(side[4]), .watchdog_request(side[5]), .clock_calendar_request(side[6]),
    .watchdog_to_nonmask(wd_nm), .sw_trap_valid(sw_v), .sw_trap_num(sw_n),
    .irq_enable(enable), .core_ready(ready), .data_vector_base_pointer(DATA_PTR),
    .host_vector_base_pointer(HOST_PTR), .vec_valid_r(valid), .vec_trap_r(trap),
    .vec_prio_r(prio), .vec_offset_r(offs), .vec_host_base_r(hostb), .vec_addr_r(addr),
    .pending_r(pend), .clock_calendar_held_r(held));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic step(); @(posedge clk); #2; endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle pulse on on-chip slots and side requests together
  task automatic pulse(input logic [31:0] m, input logic [6:0] s);
    onchip = m; side = s; step(); onchip = '0; side = '0;
  endtask
  task automatic expect_vec(input logic [4:0] t);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 30) begin step(); n++; end
    chk("dispatch", 1, valid);
    chk("trap", t, trap);
    chk("prio", dsivp_prio(t), prio);
    chk("offset", {t, 3'b000}, offs);
    chk("address", {(t[4:3] == 2'b10) ? HOST_PTR : DATA_PTR, 8'h00} + t * 8, addr);
    chk("host base", (t >= 5'h10 && t <= 5'h17), hostb);
    step();
  endtask
  // no dispatch may appear for n cycles
  task automatic expect_none(input int n); repeat (n) begin chk("quiet", 0, valid); step(); end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_slots();
    for (int t = 0; t < 32; t++) if (32'h07F6_D770 >> t & 1) begin pulse(1 << t, 0); expect_vec(t); end
    pulse(32'h0000_0884, 0); expect_none(5); // slots of shared or pin traps ignored
  endtask
  task automatic t_shared();
    logic [4:0] exp [7];
    exp = '{5'h00, 5'h07, 5'h07, 5'h0D, 5'h0D, 5'h0B, 5'h13};
    // the bench knows which source it pulsed, in place of a watchdog status poll
    for (int i = 0; i < 7; i++) begin pulse(0, 1 << i); expect_vec(exp[i]); end
    pulse(0, 7'h06); expect_vec(5'h07); expect_none(4);
  endtask
  task automatic t_soft();
    logic [4:0] tl [6];
    tl = '{5'h01, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
    for (int i = 0; i < 6; i++) begin
      sw_v = 1; sw_n = tl[i]; step(); sw_v = 0; expect_vec(tl[i]);
    end
    wd_nm = 1; pulse(0, 7'h20); expect_vec(5'h01); wd_nm = 0;
  endtask
  task automatic t_pins();
    logic [4:0] tl [5];
    tl = '{5'h02, 5'h10, 5'h03, 5'h0B, 5'h13};
    for (int i = 0; i < 5; i++) begin
      pin_low[i] = 1; expect_vec(tl[i]); pin_low[i] = 0; expect_none(5);
    end
  endtask
  task automatic t_order();
    slow = 1; pulse(32'h0102_0010, 0);
    expect_vec(5'h18); expect_vec(5'h04); expect_vec(5'h11); slow = 0; expect_none(6);
  endtask
  task automatic t_mask();
    enable[5] = 0; pulse(32'h0000_0020, 0); expect_none(6);
    chk("masked pending", 1, pend[5]);
    enable[5] = 1; expect_vec(5'h05); chk("cleared pending", 0, pend[5]);
  endtask
  // ext4 and calendar share the line only here, to show one holding off the other
  task automatic t_cal();
    pin_low[4] = 1; expect_vec(5'h13); pulse(0, 7'h40); expect_none(6);
    chk("calendar held", 1, held);
    pin_low[4] = 0; expect_vec(5'h13); chk("calendar released", 0, held);
  endtask
  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin clk = 0; forever #12.5 clk = ~clk; end
  // a hang is cut off well beyond the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin err_count++; finish_test(); end
  end
  initial begin
    resetn = 0; slow = 0; wd_nm = 0; sw_v = 0; sw_n = '0; pin_low = '0;
    side = '0; onchip = '0; enable = 32'hFFFF_FFFF;
    repeat (8) @(posedge clk);
    #2; chk("pending at reset", 32'h0000_0001, pend); resetn = 1;
    expect_vec(5'h00); chk("reset taken", 0, pend[0]);
    t_slots(); t_shared(); t_soft(); t_pins(); t_order(); t_mask(); t_cal();
    finish_test();
  end
endmodule
`default_nettype wire
